// File: rtl/tsn_conv.v
// Purpose: conversion sequencer: convert, then idle, then convert again
// Assumes: sample holds the front end result at the end of the conversion
// Notes: shutdown aborts a running conversion and keeps the last result
`include "tsn_defs.vh"
module tsn_conv #(
	parameter [23:0] CONV_CYCLES = `TSN_CONV_MS * `TSN_PCLK_KHZ,
	parameter [23:0] MS_CYCLES = `TSN_PCLK_KHZ
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// control
	input wire run,
	input wire [7:0] idle_ms,
	// front end
	input wire [10:0] sample,
	// result
	output reg [10:0] result_q,
	output reg done_q,
	output reg busy_q
);

localparam S_STOP = 2'd0;
localparam S_CONV = 2'd1;
localparam S_IDLE = 2'd2;

reg [1:0] st_q;
reg [23:0] cyc_q;
reg [7:0] ms_q;

// reset state is converting, so the first result follows power-up after one conversion time
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		st_q <= S_CONV;
		cyc_q <= 24'h000000;
		ms_q <= 8'h00;
		result_q <= 11'h000;
		done_q <= 1'b0;
		busy_q <= 1'b1;
	end else if (ce) begin
		done_q <= 1'b0;
		case (st_q)
		S_STOP: begin
			if (run) begin
				st_q <= S_CONV;
				cyc_q <= 24'h000000;
				busy_q <= 1'b1;
			end
		end
		S_CONV: begin
			if (!run) begin
				st_q <= S_STOP;
				busy_q <= 1'b0;
			end else if (cyc_q == CONV_CYCLES - 24'h000001) begin
				result_q <= sample;
				done_q <= 1'b1;
				st_q <= S_IDLE;
				cyc_q <= 24'h000000;
				ms_q <= 8'h00;
				busy_q <= 1'b0;
			end else begin
				cyc_q <= cyc_q + 24'h000001;
			end
		end
		S_IDLE: begin
			if (!run) begin
				st_q <= S_STOP;
			end else if (ms_q == idle_ms) begin
				st_q <= S_CONV;
				cyc_q <= 24'h000000;
				busy_q <= 1'b1;
			end else if (cyc_q == MS_CYCLES - 24'h000001) begin
				cyc_q <= 24'h000000;
				ms_q <= ms_q + 8'h01;
			end else begin
				cyc_q <= cyc_q + 24'h000001;
			end
		end
		default: st_q <= S_STOP;
		endcase
	end
end

endmodule // tsn_conv

// File: rtl/tsn_defs.vh
// Purpose: shared constants of the temperature sensor watchdog block
// Assumes: included by the converter and top design files of the block; the synchroniser does not use it
// Notes: offsets are apb byte addresses, pointers are link register numbers
`ifndef TSN_DEFS_VH
`define TSN_DEFS_VH

// timing, in kHz and ms as printed
`define TSN_PCLK_KHZ 25000
`define TSN_CONV_MS 28
`define TSN_PERIOD_MS 100
`define TSN_TOUT_MS 25

// apb byte offsets
`define TSN_A_TEMP 8'h00
`define TSN_A_CONF 8'h04
`define TSN_A_HYST 8'h08
`define TSN_A_OS 8'h0c
`define TSN_A_IDLE 8'h10
`define TSN_A_STAT 8'h14

// link register pointers
`define TSN_P_TEMP 3'h0
`define TSN_P_CONF 3'h1
`define TSN_P_HYST 3'h2
`define TSN_P_OS 3'h3
`define TSN_P_IDLE 3'h4

// settings register fields
`define TSN_CF_SHDN 0
`define TSN_CF_INT 1
`define TSN_CF_POL 2
`define TSN_CF_FQ_LO 3
`define TSN_CF_FQ_HI 4

// reset values: limits in 0.5 degree steps, idle time in ms
`define TSN_CONF_RST 5'h00
`define TSN_HYST_RST 9'h096
`define TSN_OS_RST 9'h0a0
`define TSN_IDLE_RST 8'h48

// lowest of the 27 link addresses
`define TSN_ADDR_BASE 7'h37

`endif

// File: rtl/tsn_sync.v
// Purpose: two flip-flop synchroniser for pins from outside the pclk domain
// Assumes: each bit is an independent level
// Notes: only the second flop is visible outside
module tsn_sync #(
	parameter W = 1,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// pins and synchronised levels
	input wire [W-1:0] d,
	output wire [W-1:0] q
);

genvar i;
generate
	for (i = 0; i < W; i = i + 1) begin : g_bit
		reg meta_q;
		reg sync_q;
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				meta_q <= RST[i];
				sync_q <= RST[i];
			end else if (ce) begin
				meta_q <= d[i];
				sync_q <= meta_q;
			end
		end
		assign q[i] = sync_q;
	end
endgenerate

endmodule // tsn_sync

// File: rtl/tsn_top.v
// Purpose: temperature sensor with thermal watchdog, two-wire link and apb port
// Assumes: scl, sda and address straps are asynchronous; temp_sample is pclk
// Notes: link and apb reach the same registers; a link write wins a tie
//
// Function
// - reading held as 11-bit two's complement, 0.125 degree per step
// - link traffic never disturbs a conversion in progress
// - reading keeps updating under back to back link access
// - a read after an update returns the new value at once
// - a one-byte read of the reading ends cleanly without lock-up
// - reset gives normal mode, comparator alarm, limits 80 and 75 degrees
// - open-drain alarm output goes active beyond the limits
// - settings select comparator or interrupt alarm behaviour
// - settings select active high or active low alarm
// - alarm acts only after a programmable count of consecutive faults
// - normal mode samples periodically, shutdown stops conversions
// - three three-state straps form one of 27 link addresses
// - link works 20 kHz to 1 MHz with a stall time-out
// - settings register holds mode, alarm mode, polarity and fault depth
// - programmable idle time between conversions, readable and writable
// - limits may be rewritten anytime and apply to later comparisons
// - compare upper nine reading bits with 9-bit limits after each conversion
// - comparator alarm has hysteresis; reads and shutdown leave it alone
// - shutdown bit selects mode; conversion starts at reset and on wake
// - default conversion every 100 ms, each taking 28 ms
//
// The register addresses and register access over APB were decided locally.
`include "tsn_defs.vh"
module tsn_top #(
	parameter [23:0] CONV_CYCLES = `TSN_CONV_MS * `TSN_PCLK_KHZ,
	parameter [23:0] MS_CYCLES = `TSN_PCLK_KHZ,
	parameter [23:0] TOUT_CYCLES = `TSN_TOUT_MS * `TSN_PCLK_KHZ
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// apb slave
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	// two-wire link
	input wire scl,
	input wire sda_in,
	output wire sda_out,
	output reg sda_oe_n,
	// alarm pin, open-drain
	input wire overheat_alarm_output_in,
	output wire overheat_alarm_output_out,
	output reg overheat_alarm_output_oe_n,
	// address straps: 00 low, 01 high, 1x floating
	input wire [1:0] address_select_0,
	input wire [1:0] address_select_1,
	input wire [1:0] address_select_2,
	// sensor front end
	input wire [10:0] temp_sample
);

localparam ST_IDLE = 3'd0;
localparam ST_RX = 3'd1;
localparam ST_RACK = 3'd2;
localparam ST_TX = 3'd3;
localparam ST_MACK = 3'd4;

wire [7:0] pins_s;
wire scl_s = pins_s[0];
wire sda_s = pins_s[1];
reg scl_p_q;
reg sda_p_q;
reg [2:0] st_q;
reg [3:0] bit_q;
reg [1:0] byte_q;
reg [7:0] shr_q;
reg [7:0] msb_q;
reg [15:0] tx_q;
reg [2:0] ptr_q;
reg rw_q;
reg lsb_q;
reg nack_q;
reg [23:0] tout_q;
reg we_q;
reg [15:0] wd_q;
reg rdq_q;
reg [4:0] conf_q;
reg [8:0] hyst_q;
reg [8:0] os_q;
reg [7:0] idle_q;
reg alarm_q;
reg int_low_q;
reg [2:0] fq_q;
reg val_q;
reg [15:0] rdw;
reg [31:0] apb_rd;
reg apb_ok;
reg [2:0] depth;
wire [10:0] temp;
wire conv_done;
wire conv_busy;

assign sda_out = 1'b0;
assign overheat_alarm_output_out = 1'b0;

tsn_sync #(
	.W(8),
	.RST(8'h03)
) u_sync (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.d({address_select_2, address_select_1, address_select_0, sda_in, scl}),
	.q(pins_s)
);

// the converter runs on its own sequencer; link activity reaches it only through the settings and idle registers
tsn_conv #(
	.CONV_CYCLES(CONV_CYCLES),
	.MS_CYCLES(MS_CYCLES)
) u_conv (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.run(~conf_q[`TSN_CF_SHDN]),
	.idle_ms(idle_q),
	.sample(temp_sample),
	.result_q(temp),
	.done_q(conv_done),
	.busy_q(conv_busy)
);

function [6:0] tern;
	input [1:0] s;
	begin
		tern = s[1] ? 7'd2 : {6'd0, s[0]};
	end
endfunction

wire [6:0] dev_addr = `TSN_ADDR_BASE + tern(pins_s[3:2]) + tern(pins_s[5:4]) * 7'd3
	+ tern(pins_s[7:6]) * 7'd9;

wire scl_rise = scl_s & ~scl_p_q;
wire scl_fall = ~scl_s & scl_p_q;
wire i2c_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
wire i2c_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
wire tout_hit = (tout_q == TOUT_CYCLES - 24'h000001);
wire wide = (ptr_q == `TSN_P_TEMP) | (ptr_q == `TSN_P_HYST) | (ptr_q == `TSN_P_OS);

// live register values: a fresh result is seen by the very next byte load
always @* begin
	case (ptr_q)
	`TSN_P_TEMP: rdw = {temp, 5'h00};
	`TSN_P_CONF: rdw = {3'h0, conf_q, 8'h00};
	`TSN_P_HYST: rdw = {hyst_q, 7'h00};
	`TSN_P_OS: rdw = {os_q, 7'h00};
	`TSN_P_IDLE: rdw = {idle_q, 8'h00};
	default: rdw = 16'h0000;
	endcase
end

// link engine: sample sda on scl rise, change sda after scl fall
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		scl_p_q <= 1'b1;
		sda_p_q <= 1'b1;
		st_q <= ST_IDLE;
		bit_q <= 4'h0;
		byte_q <= 2'h0;
		shr_q <= 8'h00;
		msb_q <= 8'h00;
		tx_q <= 16'h0000;
		ptr_q <= `TSN_P_TEMP;
		rw_q <= 1'b0;
		lsb_q <= 1'b0;
		nack_q <= 1'b1;
		tout_q <= 24'h000000;
		we_q <= 1'b0;
		wd_q <= 16'h0000;
		rdq_q <= 1'b0;
		sda_oe_n <= 1'b1;
	end else if (ce) begin
		scl_p_q <= scl_s;
		sda_p_q <= sda_s;
		we_q <= 1'b0;
		rdq_q <= 1'b0;
		if (i2c_start) begin
			st_q <= ST_RX;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
			tout_q <= 24'h000000;
			sda_oe_n <= 1'b1;
		end else if (i2c_stop || tout_hit) begin
			// a stalled scl low releases sda so the bus cannot hang
			st_q <= ST_IDLE;
			tout_q <= 24'h000000;
			sda_oe_n <= 1'b1;
		end else begin
			tout_q <= (st_q != ST_IDLE && !scl_s) ? tout_q + 24'h000001 : 24'h000000;
			case (st_q)
			ST_RX: begin
				if (scl_rise) begin
					shr_q <= {shr_q[6:0], sda_s};
					bit_q <= bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					bit_q <= 4'h0;
					st_q <= ST_RACK;
					sda_oe_n <= 1'b0;
					if (byte_q == 2'h0) begin
						rw_q <= shr_q[0];
						lsb_q <= 1'b0;
						rdq_q <= shr_q[0] && shr_q[7:1] == dev_addr;
						if (shr_q[7:1] != dev_addr) begin
							st_q <= ST_IDLE;
							sda_oe_n <= 1'b1;
						end
					end else if (byte_q == 2'h1) begin
						ptr_q <= shr_q[2:0];
						byte_q <= 2'h2;
						lsb_q <= 1'b0;
					end else if (wide && !lsb_q) begin
						msb_q <= shr_q;
						lsb_q <= 1'b1;
					end else begin
						we_q <= 1'b1;
						wd_q <= wide ? {msb_q, shr_q} : {8'h00, shr_q};
						lsb_q <= 1'b0;
					end
				end
			end
			ST_RACK: begin
				if (scl_fall) begin
					if (byte_q == 2'h0 && rw_q) begin
						st_q <= ST_TX;
						tx_q <= rdw;
						sda_oe_n <= rdw[15];
						lsb_q <= 1'b0;
					end else begin
						st_q <= ST_RX;
						sda_oe_n <= 1'b1;
						if (byte_q == 2'h0) begin
							byte_q <= 2'h1;
						end
					end
				end
			end
			ST_TX: begin
				if (scl_rise) begin
					bit_q <= bit_q + 4'h1;
				end else if (scl_fall) begin
					if (bit_q == 4'h8) begin
						bit_q <= 4'h0;
						st_q <= ST_MACK;
						sda_oe_n <= 1'b1;
					end else begin
						tx_q <= {tx_q[14:0], 1'b0};
						sda_oe_n <= tx_q[14];
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					nack_q <= sda_s;
				end else if (scl_fall) begin
					if (nack_q) begin
						// a nack after any byte, first or second, just ends the read
						st_q <= ST_IDLE;
					end else if (wide && !lsb_q) begin
						st_q <= ST_TX;
						tx_q <= {tx_q[14:0], 1'b0};
						sda_oe_n <= tx_q[14];
						lsb_q <= 1'b1;
					end else begin
						st_q <= ST_TX;
						tx_q <= rdw;
						sda_oe_n <= rdw[15];
						lsb_q <= 1'b0;
					end
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
end

// apb decode
always @* begin
	apb_ok = 1'b1;
	if (paddr == `TSN_A_TEMP) begin
		apb_rd = {{21{temp[10]}}, temp};
	end else if (paddr == `TSN_A_CONF) begin
		apb_rd = {27'h0, conf_q};
	end else if (paddr == `TSN_A_HYST) begin
		apb_rd = {23'h0, hyst_q};
	end else if (paddr == `TSN_A_OS) begin
		apb_rd = {23'h0, os_q};
	end else if (paddr == `TSN_A_IDLE) begin
		apb_rd = {24'h0, idle_q};
	end else if (paddr == `TSN_A_STAT) begin
		apb_rd = {25'h0, fq_q, st_q != ST_IDLE, int_low_q, conv_busy, alarm_q};
	end else begin
		apb_rd = 32'h00000000;
		apb_ok = 1'b0;
	end
end

// read data is registered, so a setup cycle lost to ce adds one wait state
assign pready = ce & psel & penable & val_q;
wire apb_we = pready & pwrite & apb_ok;
wire rd_evt = rdq_q | (pready & ~pwrite & apb_ok);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		val_q <= 1'b0;
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end else if (ce) begin
		val_q <= psel & ~(penable & val_q);
		prdata <= apb_rd;
		pslverr <= ~apb_ok;
	end
end

// register file; the reading itself lives in the converter
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		conf_q <= `TSN_CONF_RST;
		hyst_q <= `TSN_HYST_RST;
		os_q <= `TSN_OS_RST;
		idle_q <= `TSN_IDLE_RST;
	end else if (ce) begin
		if (we_q) begin
			if (ptr_q == `TSN_P_CONF) begin
				conf_q <= wd_q[4:0];
			end else if (ptr_q == `TSN_P_HYST) begin
				hyst_q <= wd_q[15:7];
			end else if (ptr_q == `TSN_P_OS) begin
				os_q <= wd_q[15:7];
			end else if (ptr_q == `TSN_P_IDLE) begin
				idle_q <= wd_q[7:0];
			end
		end else if (apb_we) begin
			if (paddr == `TSN_A_CONF) begin
				conf_q <= pwdata[4:0];
			end else if (paddr == `TSN_A_HYST) begin
				hyst_q <= pwdata[8:0];
			end else if (paddr == `TSN_A_OS) begin
				os_q <= pwdata[8:0];
			end else if (paddr == `TSN_A_IDLE) begin
				idle_q <= pwdata[7:0];
			end
		end
	end
end

// watchdog: faults are counted on results only, so reads and shutdown hold the fault count
wire intm = conf_q[`TSN_CF_INT];
wire over = $signed(temp[10:2]) > $signed(os_q);
wire under = $signed(temp[10:2]) < $signed(hyst_q);
wire watch_low = intm ? int_low_q : alarm_q;
wire hit = watch_low ? under : over;
wire fire = conv_done & hit & (fq_q + 3'h1 >= depth);

always @* begin
	case (conf_q[`TSN_CF_FQ_HI:`TSN_CF_FQ_LO])
	2'h0: depth = 3'd1;
	2'h1: depth = 3'd2;
	2'h2: depth = 3'd4;
	default: depth = 3'd6;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		alarm_q <= 1'b0;
		int_low_q <= 1'b0;
		fq_q <= 3'h0;
		overheat_alarm_output_oe_n <= 1'b1;
	end else if (ce) begin
		if (conv_done) begin
			if (!hit || fire) begin
				fq_q <= 3'h0;
			end else begin
				fq_q <= fq_q + 3'h1;
			end
		end
		if (fire) begin
			if (intm) begin
				alarm_q <= 1'b1;
				int_low_q <= ~int_low_q;
			end else begin
				alarm_q <= ~alarm_q;
			end
		end else if (rd_evt && intm) begin
			// only a new event in the same cycle wins over the clear by read
			alarm_q <= 1'b0;
		end
		overheat_alarm_output_oe_n <= ~(alarm_q ^ conf_q[`TSN_CF_POL]);
	end
end

endmodule // tsn_top

// File: tb/tb_temp_sensor_thermal_watchdog.sv
// Purpose: self-checking bench for the temperature watchdog block
// Assumes: shortened counts, one conversion period is 51 pclk with idle set to 1
// Notes: alarm expectations come from an integer model of limits and polarity
module tb_temp_sensor_thermal_watchdog;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, er, ack;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [31:0] rv [4] = '{32'h0, 32'h96, 32'ha0, 32'h48};
	logic pready, pslverr, scl, sda_in, sda_out, sda_oe_n, al_out, al_oe_n;
	logic [1:0] st [3];
	logic [10:0] s = 11'h000;
	logic [15:0] lv;
	logic [6:0] ad;
	int miscompares = 0, check_count = 0, cyc = 0, alarm = 0, pol = 0, os = 160, hy = 150, d;
	always #20 pclk = ~pclk;
	tsn_top #(.CONV_CYCLES(24'h28), .MS_CYCLES(24'h0a), .TOUT_CYCLES(24'hc8)) tsn_top_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .overheat_alarm_output_in(al_oe_n),
		.overheat_alarm_output_out(al_out), .overheat_alarm_output_oe_n(al_oe_n),
		.address_select_0(st[0]), .address_select_1(st[1]), .address_select_2(st[2]),
		.temp_sample(s));
	tsn_link_model tsn_link_model_inst (.pclk(pclk), .sda_oe_n(sda_oe_n), .scl(scl),
		.sda_in(sda_in));
	task give_verdict;
		if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			give_verdict;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// back to back reading accesses span more than two conversion periods
	task conv;
		repeat (40) apb(1'b0, 8'h00, 32'h0);
	endtask
	task pin(input int e);
		chk("alarm pin", 32'(e), {31'h0, al_oe_n});
	endtask
	task go(input logic [10:0] v);
		int t;
		s <= v;
		conv;
		t = $signed(v) >>> 2;
		if (t > os) alarm = 1;
		else if (t < hy) alarm = 0;
		chk("reading", {{21{v[10]}}, v}, rd);
		pin(alarm == pol);
	endtask
	initial begin
		void'($urandom(32'h4629));
		ad = 7'h37;
		for (int i = 0; i < 3; i++) begin
			d = $urandom_range(0, 2);
			st[i] = (d == 2) ? 2'h2 : 2'(d);
			ad = ad + 7'(d * (i == 0 ? 1 : i == 1 ? 3 : 9));
		end
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 + 4 * i), 32'h0);
			chk("reset value", rv[i], rd);
		end
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		apb(1'b1, 8'h10, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk("idle time", 32'h1, rd);
		for (int i = 0; i < 3; i++) go(11'($urandom_range(0, 1099) - 500));
		go(11'h284);
		go(11'h25c);
		go(11'h254);
		apb(1'b1, 8'h08, 32'h40);
		apb(1'b1, 8'h0c, 32'h50);
		os = 80;
		hy = 64;
		go(11'h180);
		apb(1'b1, 8'h0c, 32'ha0);
		apb(1'b1, 8'h08, 32'h96);
		os = 160;
		hy = 150;
		pol = 1;
		apb(1'b1, 8'h04, 32'h4);
		go(11'h254);
		go(11'h284);
		apb(1'b1, 8'h04, 32'h5);
		s <= 11'h000;
		conv;
		chk("held reading", 32'h284, rd);
		pin(alarm == pol);
		apb(1'b1, 8'h04, 32'h4);
		go(11'h000);
		pol = 0;
		apb(1'b1, 8'h04, 32'h18);
		s <= 11'h284;
		conv;
		pin(1);
		repeat (2) conv;
		go(11'h284);
		apb(1'b1, 8'h04, 32'h0);
		go(11'h000);
		apb(1'b1, 8'h04, 32'h2);
		s <= 11'h284;
		repeat (120) @(posedge pclk);
		pin(0);
		apb(1'b0, 8'h14, 32'h0);
		repeat (3) @(posedge pclk);
		pin(1);
		repeat (120) @(posedge pclk);
		pin(1);
		s <= 11'h000;
		repeat (120) @(posedge pclk);
		pin(0);
		apb(1'b1, 8'h04, 32'h0);
		alarm = 1;
		go(11'h1a5);
		tsn_link_model_inst.rd_temp(ad, 2, lv, ack);
		chk("link ack", 32'h0, {31'h0, ack});
		chk("link reading", 32'h34a0, {16'h0, lv});
		tsn_link_model_inst.rd_temp(ad, 1, lv, ack);
		chk("link one byte", 32'h3400, {16'h0, lv});
		// address byte, then the clock is left low: only the time-out frees the link
		tsn_link_model_inst.start;
		tsn_link_model_inst.send({ad, 1'b0}, ack);
		apb(1'b0, 8'h14, 32'h0);
		chk("link busy", 32'h1, {31'h0, rd[3]});
		repeat (220) @(posedge pclk);
		apb(1'b0, 8'h14, 32'h0);
		chk("link stall", 32'h0, {31'h0, rd[3]});
		go(11'h07f);
		// frozen clock enable: an over-limit sample must not reach the pin
		ce <= 1'b0;
		s <= 11'h284;
		repeat (150) @(posedge pclk);
		pin(alarm == pol);
		ce <= 1'b1;
		go(11'h284);
		give_verdict;
	end
endmodule // tb_temp_sensor_thermal_watchdog

// File: tb/tsn_assertions.sv
// Purpose: port checker for the temperature watchdog block
// Assumes: everything watched lives in the pclk domain
// Notes: bound to every tsn_top instance
module tsn_assertions (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// link and alarm
	input wire logic scl,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic overheat_alarm_output_out,
	input wire logic overheat_alarm_output_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = pready && !pwrite;
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	unmapped_error_a: assert property (pready && paddr > 8'h14 |-> pslverr)
		else $error("unmapped access without error");
	mapped_no_error_a: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access flagged as error");
	reading_sign_a: assert property (rd && paddr == 8'h00 |-> prdata[31:11] == {21{prdata[10]}})
		else $error("reading not sign extended");
	settings_width_a: assert property (rd && paddr == 8'h04 |-> prdata[31:5] == 27'h0)
		else $error("settings wider than five bits");
	limit_width_a: assert property (rd && paddr[7:3] == 5'h1 |-> prdata[31:9] == 23'h0)
		else $error("limit wider than nine bits");
	idle_width_a: assert property (rd && paddr == 8'h10 |-> prdata[31:8] == 24'h0)
		else $error("idle time wider than eight bits");
	open_drain_a: assert property (!overheat_alarm_output_out && !sda_out)
		else $error("open-drain pin driven high");
	sda_grab_a: assert property ($fell(sda_oe_n) |-> !scl)
		else $error("data line taken while clock high");
	reset_alarm_a: assert property ($rose(presetn) |-> overheat_alarm_output_oe_n)
		else $error("alarm active out of reset");
	cover property ($fell(overheat_alarm_output_oe_n));
	cover property ($rose(overheat_alarm_output_oe_n));
	cover property ($fell(sda_oe_n));
	cover property (pready && pslverr);
endmodule // tsn_assertions

bind tsn_top tsn_assertions tsn_assertions_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .scl(scl), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.overheat_alarm_output_out(overheat_alarm_output_out),
	.overheat_alarm_output_oe_n(overheat_alarm_output_oe_n));

// File: tb/tsn_link_model.sv
// Purpose: two-wire controller model that reads the reading register
// Assumes: data line has a pull-up; only this model drives the clock
// Notes: one link period is eight pclk (320 ns); clock stands high between frames
module tsn_link_model (
	// clock
	input wire logic pclk,
	// bus
	input wire logic sda_oe_n,
	output logic scl,
	output logic sda_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv = 1'b1;
	initial scl = 1'b1;
	// wired-and with the pull-up: a released line reads high, never the last value
	assign sda_in = drv & sda_oe_n;
	task q;
		repeat (2) @(posedge pclk);
	endtask
	task bit_io(input logic b, output logic r);
		drv <= b;
		q;
		scl <= 1'b1;
		q;
		r = sda_in;
		q;
		scl <= 1'b0;
		q;
	endtask
	task start;
		drv <= 1'b1;
		q;
		scl <= 1'b1;
		q;
		drv <= 1'b0;
		q;
		scl <= 1'b0;
		q;
	endtask
	task send(input logic [7:0] b, output logic a);
		logic x;
		for (int i = 7; i >= 0; i--) bit_io(b[i], x);
		bit_io(1'b1, a);
	endtask
	task rd_temp(input logic [6:0] ad, input int nb, output logic [15:0] v, output logic nack);
		logic a0, a1, a2, x;
		v = 16'h0;
		start;
		send({ad, 1'b0}, a0);
		send(8'h00, a1);
		start;
		send({ad, 1'b1}, a2);
		for (int i = 0; i < 8 * nb; i++) begin
			bit_io(1'b1, v[15 - i]);
			if (i % 8 == 7) bit_io(i == 8 * nb - 1, x);
		end
		drv <= 1'b0;
		q;
		scl <= 1'b1;
		q;
		drv <= 1'b1;
		q;
		nack = a0 | a1 | a2;
	endtask
endmodule // tsn_link_model
